// ===== inc/npi_pkg.sv
// Shared constants and types of the nested priority interrupt controller
package npi_pkg;

  // ==========================================================================
  // Sizes
  localparam int NPI_NUM_VEC = 14;
  localparam int NPI_NUM_PRIO_REGS = 4;
  localparam int NPI_FIELDS_PER_REG = 4;

  // ==========================================================================
  // Two-bit priority codes {prio_bit_high, prio_bit_low}
  localparam logic [1:0] NPI_CODE_LVL0 = 2'h2;
  localparam logic [1:0] NPI_CODE_LVL1 = 2'h1;
  localparam logic [1:0] NPI_CODE_LVL2 = 2'h0;
  localparam logic [1:0] NPI_CODE_LVL3 = 2'h3;

  // Condition-code register bit positions
  localparam int NPI_CC_PRIO_HIGH_BIT = 5;
  localparam int NPI_CC_PRIO_LOW_BIT = 3;

  // Condition-code reset value: both priority bits set, level 3
  localparam logic [7:0] NPI_CC_RESET = 8'hea;

  // Priority register reset value
  localparam logic [7:0] NPI_PRIO_REG_RESET = 8'hff;

  // ==========================================================================
  // Vector addresses
  localparam logic [15:0] NPI_VEC_RESET = 16'hfffe;
  localparam logic [15:0] NPI_VEC_TRAP = 16'hfffc;
  localparam logic [15:0] NPI_VEC_BASE = 16'hfffa;
  localparam logic [15:0] NPI_VEC_LOW_END = 16'hffe0;

  // Vectors able to end HALT: index 0 (pin) and external lines 1..5
  localparam logic [13:0] NPI_HALT_WAKE_MASK = 14'h003f;

  typedef enum logic [2:0] {
    NPI_SRC_NONE,
    NPI_SRC_RESET,
    NPI_SRC_TRAP,
    NPI_SRC_PIN,
    NPI_SRC_MASKABLE
  } npi_src_type;

  // Decode two-bit code to numeric level 0..3
  function automatic logic [1:0] npi_level(input logic [1:0] code);
    case (code)
      NPI_CODE_LVL0: npi_level = 2'h0;
      NPI_CODE_LVL1: npi_level = 2'h1;
      NPI_CODE_LVL2: npi_level = 2'h2;
      default: npi_level = 2'h3;
    endcase
  endfunction : npi_level

endpackage : npi_pkg

// ===== inc/npi_arb_if.sv
// Carrier between the controller top and its arbiter
`timescale 1ns/1ns
interface npi_arb_if #(parameter int N = 14);
  logic [N-1:0] pend;
  logic [2*N-1:0] prio_codes;
  logic [1:0] cur_code;
  logic halt_exit;
  logic found;
  logic [$clog2(N)-1:0] idx;
  modport ctrl (output pend, output prio_codes, output cur_code, output halt_exit,
    input found, input idx);
  modport arb (input pend, input prio_codes, input cur_code, input halt_exit,
    output found, output idx);
endinterface : npi_arb_if

// ===== design/npi_edge_latch.sv
// Edge detector with a sticky request latch for one interrupt line
`timescale 1ns/1ns
module npi_edge_latch
  import npi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_line,
  input wire logic i_falling,
  input wire logic i_clear,
  output logic o_pend
);

  logic line_q;
  logic armed_q;
  logic edge_hit;

  // First sample only primes the history, so a line idling high is no edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      line_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      line_q <= i_line;
      armed_q <= 1'b1;
    end
  end

  assign edge_hit = armed_q & (i_falling ? (line_q & ~i_line) : (~line_q & i_line));

  // A new edge in the clear cycle is kept
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pend <= 1'b0;
    end else if (edge_hit) begin
      o_pend <= 1'b1;
    end else if (i_clear) begin
      o_pend <= 1'b0;
    end
  end

endmodule : npi_edge_latch

// ===== design/npi_arbiter.sv
// Two-step priority arbiter: software level first, fixed order second
`timescale 1ns/1ns
module npi_arbiter
  import npi_pkg::*;
#(
  parameter int N = 14
)
(
  npi_arb_if.arb bus
);

  logic [1:0] best_lvl;
  logic [1:0] lvl;
  logic [1:0] cur_lvl;

  always_comb begin
    bus.found = 1'b0;
    bus.idx = '0;
    best_lvl = 2'h0;
    lvl = 2'h0;
    cur_lvl = npi_level(bus.cur_code);
    // Low index is highest fixed priority, so only a strictly better level wins
    for (int i = 0; i < N; i++) begin
      lvl = npi_level(bus.prio_codes[2*i +: 2]);
      if (bus.pend[i] && (lvl > cur_lvl)
          && (!bus.halt_exit || NPI_HALT_WAKE_MASK[i])
          && (!bus.found || lvl > best_lvl)) begin
        bus.found = 1'b1;
        bus.idx = ($clog2(N))'(i);
        best_lvl = lvl;
      end
    end
  end

endmodule : npi_arbiter

// ===== design/npi_ctrl.sv
// Nested priority interrupt controller top
// Overview of operation
// - Level codes: 0=10, 1=01, 2=00, 3=11 as high/low bit pairs.
// - Current priority sits in condition code bits 5 and 3.
// - Up to 16 fixed vectors and four software nesting levels.
// - Vector addresses lie from FFE0h to FFFFh in fixed priority order.
// - Entry waits for the running instruction to finish.
// - Entry stacks program counter, index, accumulator and condition code.
// - After stacking, current priority loads from the vector's priority field.
// - Then the program counter loads the vector address and fetch starts.
// - Return pops saved registers, restoring the priority bits.
// - Highest software level wins; fixed order breaks ties.
// - Unserviced edge and trap requests stay latched until they rank highest; peripheral ones follow flag AND enable.
// - Reset, pin interrupt and trap ignore the current level.
// - Non-maskable entry stacks except reset, forces level 3; reset and pin requests end HALT, a pending trap does not.
// - Configured edge on the dedicated pin raises the pin interrupt.
// - Trap instruction raises the trap, handled like the pin interrupt.
// - Reset ranks highest; code after reset runs at level 3.
// - Maskable request serviced only if enabled and above current level.
// - Edge external requests latch and clear on service entry.
// - Selected pins of one group are ORed onto their line.
// - Peripheral request is flag AND enable.
// - Flag clear sequence drops the peripheral request latch.
// - Any request ends WAIT; only wake-capable ones end HALT, served first.
// - Four priority registers of two-bit fields, reset to all ones.
// - Writing the level 0 code to a field keeps the old value.
`timescale 1ns/1ns
module npi_ctrl
  import npi_pkg::*;
#(
  parameter int NUM_EXT = 5,
  parameter int PINS_PER_GROUP = 8,
  parameter int NUM_PERIPH = 8
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [NUM_EXT*PINS_PER_GROUP-1:0] i_ext_pins,
  input wire logic [NUM_EXT*PINS_PER_GROUP-1:0] i_ext_pin_sel,
  input wire logic [NUM_EXT-1:0] i_ext_falling,
  input wire logic [NUM_EXT-1:0] i_ext_enable,
  input wire logic i_nmi_pin,
  input wire logic i_nmi_falling,
  input wire logic [NUM_PERIPH-1:0] i_periph_flag,
  input wire logic [NUM_PERIPH-1:0] i_periph_enable,
  input wire logic [NUM_PERIPH-1:0] i_periph_flag_clear,
  input wire logic i_trap_exec,
  input wire logic i_instr_end,
  input wire logic i_stack_done,
  input wire logic i_return_from_interrupt,
  input wire logic [7:0] i_popped_cc,
  input wire logic i_cc_write,
  input wire logic [7:0] i_cc_wdata,
  input wire logic i_in_wait,
  input wire logic i_in_halt,
  input wire logic [1:0] i_prio_reg_sel,
  input wire logic i_prio_reg_write,
  input wire logic [7:0] i_prio_reg_wdata,
  output logic [7:0] o_prio_reg_rdata,
  output logic [7:0] o_condition_code_reg,
  output logic o_stack_req,
  output logic o_vector_load,
  output logic [15:0] o_vector_addr,
  output logic o_wake,
  output logic o_busy
);

  localparam int N = NPI_NUM_VEC;
  localparam int IW = $clog2(N);

  // ==========================================================================
  // State
  typedef enum logic [2:0] {
    NPI_IDLE,
    NPI_WAIT_INSTR,
    NPI_STACK,
    NPI_LOAD
  } npi_state_type;

  npi_state_type state_q;
  npi_src_type src_q;
  logic [IW-1:0] idx_q;
  logic [7:0] cc_q;
  logic [7:0] vector_priority_regs [NPI_NUM_PRIO_REGS];
  logic nmi_pend;
  logic trap_q;
  logic reset_pend_q;
  logic halt_exit_q;
  logic [NUM_PERIPH-1:0] periph_pend_q;
  logic [NUM_EXT-1:0] ext_pend;
  logic [NUM_EXT-1:0] ext_line;
  logic [N-1:0] pend_all;
  logic [N-1:0] enabled;
  logic [N-1:0] pend_en;
  logic enter_pulse;
  logic any_nonmask;
  logic any_wake;
  logic any_req;

  npi_arb_if #(.N(N)) arb_bus ();

  // ==========================================================================
  // External lines
  // Selected pins of one group behave as a single line
  always_comb begin
    for (int g = 0; g < NUM_EXT; g++) begin
      ext_line[g] = |(i_ext_pins[g*PINS_PER_GROUP +: PINS_PER_GROUP]
                     & i_ext_pin_sel[g*PINS_PER_GROUP +: PINS_PER_GROUP]);
    end
  end

  // Entry into a service routine clears edge latches of that vector
  assign enter_pulse = (state_q == NPI_LOAD);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
      npi_edge_latch u_ext (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_line(ext_line[gi]),
        .i_falling(i_ext_falling[gi]),
        .i_clear(enter_pulse && src_q == NPI_SRC_MASKABLE
                 && idx_q == IW'(gi + 1)),
        .o_pend(ext_pend[gi])
      );
    end
  endgenerate

  // The pin latch clears only on its own entry, never on a maskable one
  npi_edge_latch u_nmi (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_line(i_nmi_pin),
    .i_falling(i_nmi_falling),
    .i_clear(enter_pulse && src_q == NPI_SRC_PIN),
    .o_pend(nmi_pend)
  );

  // ==========================================================================
  // Peripheral request latches
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      periph_pend_q <= '0;
    end else begin
      for (int p = 0; p < NUM_PERIPH; p++) begin
        // The clear sequence beats a flag still showing, so a waiting request is lost
        if (i_periph_flag_clear[p]) begin
          periph_pend_q[p] <= 1'b0;
        end else if (i_periph_flag[p] && i_periph_enable[p]) begin
          periph_pend_q[p] <= 1'b1;
        end else begin
          periph_pend_q[p] <= 1'b0;
        end
      end
    end
  end

  // Vector 0 is the pin interrupt; its field is kept but not used
  always_comb begin
    pend_all = '0;
    enabled = '0;
    for (int v = 1; v <= NUM_EXT; v++) begin
      pend_all[v] = ext_pend[v-1];
      enabled[v] = i_ext_enable[v-1];
    end
    for (int p = 0; p < NUM_PERIPH; p++) begin
      pend_all[NUM_EXT+1+p] = periph_pend_q[p];
      enabled[NUM_EXT+1+p] = 1'b1;
    end
  end

  // ==========================================================================
  // Arbitration
  assign pend_en = pend_all & enabled;
  assign arb_bus.pend = pend_en;
  assign arb_bus.cur_code = {cc_q[NPI_CC_PRIO_HIGH_BIT], cc_q[NPI_CC_PRIO_LOW_BIT]};
  assign arb_bus.halt_exit = halt_exit_q;
  // Fields are read live, so a rewrite takes effect at the next entry
  always_comb begin
    for (int r = 0; r < NPI_NUM_PRIO_REGS; r++) begin
      for (int f = 0; f < NPI_FIELDS_PER_REG; f++) begin
        if (r*NPI_FIELDS_PER_REG + f < N) begin
          arb_bus.prio_codes[2*(r*NPI_FIELDS_PER_REG+f) +: 2] =
            vector_priority_regs[r][2*f +: 2];
        end
      end
    end
  end

  npi_arbiter #(.N(N)) u_arb (
    .bus(arb_bus.arb)
  );

  assign any_nonmask = reset_pend_q | trap_q | nmi_pend;
  assign any_req = any_nonmask | arb_bus.found;
  assign any_wake = nmi_pend | reset_pend_q | |(pend_en & NPI_HALT_WAKE_MASK);
  // Any enabled request ends WAIT, whatever its level; HALT needs a wake-capable one
  assign o_wake = i_in_halt ? any_wake
                            : (i_in_wait & (any_req | |pend_en));
  assign o_busy = (state_q != NPI_IDLE);
  assign o_condition_code_reg = cc_q;

  // ==========================================================================
  // Priority registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int r = 0; r < NPI_NUM_PRIO_REGS; r++) begin
        vector_priority_regs[r] <= NPI_PRIO_REG_RESET;
      end
    end else if (i_prio_reg_write) begin
      for (int f = 0; f < NPI_FIELDS_PER_REG; f++) begin
        // Level 0 codes and the fixed upper half of the last register are not stored
        if (i_prio_reg_wdata[2*f +: 2] != NPI_CODE_LVL0
            && !(i_prio_reg_sel == 2'h3 && f >= 2)) begin
          vector_priority_regs[i_prio_reg_sel][2*f +: 2] <= i_prio_reg_wdata[2*f +: 2];
        end
      end
    end
  end

  assign o_prio_reg_rdata = vector_priority_regs[i_prio_reg_sel];

  // ==========================================================================
  // Trap and halt-exit flags
  // A trap raised in the cycle its predecessor is entered is kept, not lost
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      trap_q <= 1'b0;
    end else if (i_trap_exec) begin
      trap_q <= 1'b1;
    end else if (enter_pulse && src_q == NPI_SRC_TRAP) begin
      trap_q <= 1'b0;
    end
  end

  // First entry after HALT is restricted to wake-capable vectors
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      halt_exit_q <= 1'b0;
    end else if (i_in_halt) begin
      halt_exit_q <= 1'b1;
    end else if (enter_pulse) begin
      halt_exit_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Entry sequence
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // Reset starts in LOAD, so its vector is issued without stacking
      state_q <= NPI_LOAD;
      src_q <= NPI_SRC_RESET;
      idx_q <= '0;
      reset_pend_q <= 1'b1;
    end else begin
      case (state_q)
        NPI_IDLE: begin
          // A request seen in HALT waits until the core has left it
          if (any_req && !i_in_halt) begin
            state_q <= NPI_WAIT_INSTR;
          end
        end
        NPI_WAIT_INSTR: begin
          if (i_instr_end) begin
            state_q <= NPI_STACK;
            // Choice is frozen here; later arrivals wait for the next entry
            idx_q <= arb_bus.idx;
            if (reset_pend_q) begin
              src_q <= NPI_SRC_RESET;
            end else if (trap_q) begin
              src_q <= NPI_SRC_TRAP;
            end else if (nmi_pend) begin
              src_q <= NPI_SRC_PIN;
            end else if (arb_bus.found) begin
              src_q <= NPI_SRC_MASKABLE;
            end else begin
              state_q <= NPI_IDLE;
            end
          end
        end
        NPI_STACK: begin
          if (i_stack_done) begin
            state_q <= NPI_LOAD;
          end
        end
        NPI_LOAD: begin
          state_q <= NPI_IDLE;
          reset_pend_q <= 1'b0;
        end
        default: state_q <= NPI_IDLE;
      endcase
    end
  end

  assign o_stack_req = (state_q == NPI_STACK);

  // ==========================================================================
  // Condition code priority bits
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cc_q <= NPI_CC_RESET;
    // Entry beats a return or a software write in the same cycle
    end else if (enter_pulse) begin
      if (src_q == NPI_SRC_MASKABLE) begin
        cc_q[NPI_CC_PRIO_HIGH_BIT] <= arb_bus.prio_codes[2*idx_q+1];
        cc_q[NPI_CC_PRIO_LOW_BIT] <= arb_bus.prio_codes[2*idx_q];
      end else begin
        cc_q[NPI_CC_PRIO_HIGH_BIT] <= NPI_CODE_LVL3[1];
        cc_q[NPI_CC_PRIO_LOW_BIT] <= NPI_CODE_LVL3[0];
      end
    end else if (i_return_from_interrupt) begin
      cc_q <= i_popped_cc;
    end else if (i_cc_write) begin
      cc_q <= i_cc_wdata;
    end
  end

  // ==========================================================================
  // Vector output
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_vector_load <= 1'b0;
      o_vector_addr <= NPI_VEC_RESET;
    end else begin
      // One-cycle pulse; the address stands until the next entry
      o_vector_load <= enter_pulse;
      if (enter_pulse) begin
        case (src_q)
          NPI_SRC_RESET: o_vector_addr <= NPI_VEC_RESET;
          NPI_SRC_TRAP: o_vector_addr <= NPI_VEC_TRAP;
          NPI_SRC_PIN: o_vector_addr <= NPI_VEC_BASE;
          // Fixed order descends from the top of memory, two bytes each
          default: o_vector_addr <= NPI_VEC_BASE - {11'h000, idx_q, 1'b0};
        endcase
      end
    end
  end

endmodule : npi_ctrl

// ===== tb/npi_core_model.sv
// Core model: ends instructions and stacks context on request
`timescale 1ns/1ns
module npi_core_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_stack_req,
  input wire logic [3:0] i_delay,
  output logic o_instr_end,
  output logic o_stack_done
);
  logic [3:0] wait_q;
  // ==========================================================================
  // Two-cycle instructions, so entry has to wait for an end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) o_instr_end <= 1'h0;
    else o_instr_end <= !o_instr_end;
  end
  // Done is one cycle, seen while the request still stands
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_q <= 4'h0;
      o_stack_done <= 1'h0;
    end else begin
      wait_q <= i_stack_req ? wait_q + 4'h1 : 4'h0;
      o_stack_done <= i_stack_req && !o_stack_done && (wait_q >= i_delay);
    end
  end
endmodule : npi_core_model

// ===== tb/npi_ctrl_checker.sv
// Concurrent checks on the interrupt controller ports
`timescale 1ns/1ns
module npi_ctrl_checker
  import npi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_instr_end,
  input wire logic i_stack_done,
  input wire logic i_return_from_interrupt,
  input wire logic [7:0] i_popped_cc,
  input wire logic [1:0] i_prio_reg_sel,
  input wire logic i_prio_reg_write,
  input wire logic [7:0] i_prio_reg_wdata,
  input wire logic [7:0] o_prio_reg_rdata,
  input wire logic [7:0] o_condition_code_reg,
  input wire logic o_stack_req,
  input wire logic o_vector_load,
  input wire logic [15:0] o_vector_addr
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic [1:0] cc_code;
  assign cc_code = {o_condition_code_reg[5], o_condition_code_reg[3]};
  function automatic int lv(input logic [1:0] c);
    return (c == 2'h2) ? 0 : (c == 2'h1) ? 1 : (c == 2'h0) ? 2 : 3;
  endfunction : lv
  // ==========================================================================
  // Entry steps
  sequence s_stacked;
    o_stack_req && i_stack_done;
  endsequence
  sequence s_load;
    !o_stack_req ##1 o_vector_load;
  endsequence
  AST_STACK_HOLD: assert property (o_stack_req && !i_stack_done |=> o_stack_req)
    else $error("stack request dropped early");
  AST_ENTRY_SEQ: assert property (s_stacked |=> s_load)
    else $error("vector load not two cycles after stacking");
  AST_AFTER_INSTR: assert property ($rose(o_stack_req) |-> $past(i_instr_end))
    else $error("stacking began before instruction end");
  AST_VEC_RANGE: assert property (
    o_vector_load |-> o_vector_addr >= NPI_VEC_LOW_END && !o_vector_addr[0])
    else $error("vector address out of range");
  AST_NMI_LVL3: assert property (
    o_vector_load && o_vector_addr >= NPI_VEC_BASE |-> cc_code == NPI_CODE_LVL3)
    else $error("non-maskable entry not at level 3");
  AST_LVL_RISE: assert property (
    o_vector_load && o_vector_addr < NPI_VEC_BASE |-> lv(cc_code) > lv($past(cc_code, 3)))
    else $error("maskable entry not above previous level");
  AST_RET_RESTORE: assert property (
    i_return_from_interrupt
    |=> cc_code == {$past(i_popped_cc[5]), $past(i_popped_cc[3])})
    else $error("return did not restore priority bits");
  AST_FIELD_WRITE: assert property (
    i_prio_reg_write && i_prio_reg_wdata[1:0] != NPI_CODE_LVL0 ##1 $stable(i_prio_reg_sel)
    |-> o_prio_reg_rdata[1:0] == $past(i_prio_reg_wdata[1:0]))
    else $error("priority field write lost");
  AST_LVL0_KEEP: assert property (
    i_prio_reg_write && i_prio_reg_wdata[5:4] == NPI_CODE_LVL0 ##1 $stable(i_prio_reg_sel)
    |-> o_prio_reg_rdata[5:4] == $past(o_prio_reg_rdata[5:4]))
    else $error("level 0 code was stored");
  AST_RO_BITS: assert property (i_prio_reg_sel == 2'h3 |-> o_prio_reg_rdata[7:4] == 4'hf)
    else $error("read-only bits not ones");
endmodule : npi_ctrl_checker
bind npi_ctrl npi_ctrl_checker u_chk (.i_clk, .i_rst_b, .i_instr_end, .i_stack_done,
  .i_return_from_interrupt, .i_popped_cc, .i_prio_reg_sel, .i_prio_reg_write,
  .i_prio_reg_wdata, .o_prio_reg_rdata, .o_condition_code_reg, .o_stack_req,
  .o_vector_load, .o_vector_addr);

// ===== tb/tb_npi_ctrl.sv
// Self-checking bench of the nested priority interrupt controller
`timescale 1ns/1ns
module tb_npi_ctrl;
  import npi_pkg::*;
  logic i_clk = 1'h0, i_rst_b = 1'h0, i_nmi_pin = 1'h1, i_nmi_falling = 1'h1;
  logic [39:0] i_ext_pins = 40'h0, i_ext_pin_sel = 40'h0;
  logic [4:0] i_ext_falling = 5'h0, i_ext_enable = 5'h1f;
  logic [7:0] i_periph_flag = 8'h0, i_periph_enable = 8'hff, i_periph_flag_clear = 8'h0;
  logic i_trap_exec = 1'h0, i_return_from_interrupt = 1'h0, i_cc_write = 1'h0;
  logic i_in_wait = 1'h0, i_in_halt = 1'h0, i_prio_reg_write = 1'h0;
  logic [7:0] i_popped_cc = 8'h0, i_cc_wdata = 8'h0, i_prio_reg_wdata = 8'h0;
  logic [1:0] i_prio_reg_sel = 2'h0;
  logic [3:0] delay = 4'h0;
  logic i_instr_end, i_stack_done, o_stack_req, o_vector_load, o_wake, o_busy;
  logic [7:0] o_prio_reg_rdata, o_condition_code_reg;
  logic [15:0] o_vector_addr;
  int n_errors = 0, check_count = 0;
  npi_ctrl dut (.i_clk, .i_rst_b, .i_ext_pins, .i_ext_pin_sel, .i_ext_falling, .i_ext_enable,
    .i_nmi_pin, .i_nmi_falling, .i_periph_flag, .i_periph_enable, .i_periph_flag_clear,
    .i_trap_exec, .i_instr_end, .i_stack_done, .i_return_from_interrupt, .i_popped_cc,
    .i_cc_write, .i_cc_wdata, .i_in_wait, .i_in_halt, .i_prio_reg_sel, .i_prio_reg_write,
    .i_prio_reg_wdata, .o_prio_reg_rdata, .o_condition_code_reg, .o_stack_req, .o_vector_load,
    .o_vector_addr, .o_wake, .o_busy);
  npi_core_model core (.i_clk, .i_rst_b, .i_stack_req(o_stack_req), .i_delay(delay),
    .o_instr_end(i_instr_end), .o_stack_done(i_stack_done));
  initial forever #5 i_clk = !i_clk;
  // ==========================================================================
  // Shared tasks
  function automatic logic [7:0] mk_cc(input logic [1:0] c);
    return {2'h3, c[1], 1'h0, c[0], 3'h2};
  endfunction : mk_cc
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic wr_prio(input logic [1:0] s, input logic [7:0] d);
    @(posedge i_clk);
    i_prio_reg_sel <= s;
    i_prio_reg_wdata <= d;
    i_prio_reg_write <= 1'h1;
    @(posedge i_clk);
    i_prio_reg_write <= 1'h0;
    #1;
  endtask : wr_prio
  task automatic ret(input logic [1:0] c);
    @(posedge i_clk);
    i_return_from_interrupt <= 1'h1;
    i_popped_cc <= mk_cc(c);
    @(posedge i_clk);
    i_return_from_interrupt <= 1'h0;
    #1 chk({o_condition_code_reg[5], o_condition_code_reg[3]}, c);
  endtask : ret
  // Entry must land within the bound; address and loaded level checked
  task automatic wait_load(input logic [15:0] a, input logic [1:0] c);
    int k;
    for (k = 0; k < 60 && o_vector_load !== 1'h1; k++) @(posedge i_clk) #1;
    chk(o_vector_load, 1'h1);
    chk(o_vector_addr, a);
    chk({o_condition_code_reg[5], o_condition_code_reg[3]}, c);
  endtask : wait_load
  task automatic no_load(input int n);
    logic seen;
    seen = 1'h0;
    repeat (n) @(posedge i_clk) #1 seen |= o_vector_load;
    chk(seen, 1'h0);
  endtask : no_load
  // ==========================================================================
  // Tests
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'h1;
    @(posedge i_clk) #1;
    wait_load(NPI_VEC_RESET, NPI_CODE_LVL3);
    for (int s = 0; s < 4; s++) begin
      @(posedge i_clk);
      i_prio_reg_sel <= s[1:0];
      #1 chk(o_prio_reg_rdata, 8'hff);
    end
    wr_prio(2'h0, 8'hcf);
    wr_prio(2'h0, 8'h64);
    chk(o_prio_reg_rdata, 8'h44);
    wr_prio(2'h3, 8'h00);
    chk(o_prio_reg_rdata, 8'hf0);
    wr_prio(2'h1, 8'hdf);
    @(posedge i_clk);
    i_cc_write <= 1'h1;
    i_cc_wdata <= mk_cc(NPI_CODE_LVL0);
    @(posedge i_clk);
    i_cc_write <= 1'h0;
    #1 chk(o_condition_code_reg, 8'he2);
    i_ext_pin_sel[7:0] <= 8'h28;
    i_ext_pins[5] <= 1'h1;
    wait_load(16'hfff8, NPI_CODE_LVL1);
    i_ext_pins[3] <= 1'h1;
    ret(NPI_CODE_LVL0);
    no_load(10);
    i_ext_pins[5:3] <= 3'h0;
    delay <= 4'h3;
    i_periph_flag[2:0] <= 3'h7;
    wait_load(16'hffec, NPI_CODE_LVL3);
    no_load(10);
    i_trap_exec <= 1'h1;
    @(posedge i_clk) i_trap_exec <= 1'h0;
    @(posedge i_clk) #1 chk(o_busy, 1'h1);
    wait_load(NPI_VEC_TRAP, NPI_CODE_LVL3);
    ret(NPI_CODE_LVL3);
    i_periph_flag[1] <= 1'h0;
    ret(NPI_CODE_LVL0);
    wait_load(16'hffea, NPI_CODE_LVL3);
    i_periph_flag[2] <= 1'h0;
    ret(NPI_CODE_LVL0);
    wait_load(16'hffee, NPI_CODE_LVL1);
    i_periph_flag[0] <= 1'h0;
    ret(NPI_CODE_LVL3);
    i_periph_flag[3] <= 1'h1;
    repeat (3) @(posedge i_clk);
    i_periph_flag_clear[3] <= 1'h1;
    ret(NPI_CODE_LVL0);
    i_periph_flag[3] <= 1'h0;
    i_periph_flag_clear[3] <= 1'h0;
    no_load(10);
    i_nmi_pin <= 1'h0;
    wait_load(NPI_VEC_BASE, NPI_CODE_LVL3);
    ret(NPI_CODE_LVL0);
    i_in_halt <= 1'h1;
    i_periph_flag[1] <= 1'h1;
    repeat (3) @(posedge i_clk) #1;
    chk(o_wake, 1'h0);
    chk(o_busy, 1'h0);
    i_ext_pin_sel[15:8] <= 8'h01;
    i_ext_pins[8] <= 1'h1;
    repeat (3) @(posedge i_clk) #1;
    chk(o_wake, 1'h1);
    i_in_halt <= 1'h0;
    wait_load(16'hfff6, NPI_CODE_LVL2);
    ret(NPI_CODE_LVL0);
    wait_load(16'hffec, NPI_CODE_LVL3);
    i_periph_flag[1] <= 1'h0;
    ret(NPI_CODE_LVL3);
    i_in_wait <= 1'h1;
    i_periph_flag[4] <= 1'h1;
    repeat (3) @(posedge i_clk) #1;
    chk(o_wake, 1'h1);
    complete_run();
  end
endmodule : tb_npi_ctrl
